// File: common/rtt_consts.svh
// Constants of the reset time-out and reset-cause tracker.
// Assumes the includer works at one 125 MHz clock.
`ifndef RTT_CONSTS_SVH
`define RTT_CONSTS_SVH
`define RTT_CLK_HZ 125000000
`define RTT_MS_CYCLES (`RTT_CLK_HZ / 1000)
`define RTT_POWER_UP_DELAY_TIMER_MS 72
`define RTT_PLL_MS 2
`define RTT_OST_PERIODS 1024
`define RTT_CNT_W 11
`define RTT_PC_RESET 21'h000000
`define RTT_VEC_HIGH 21'h000008
`define RTT_VEC_LOW 21'h000018
`define RTT_PC_STEP 21'h000002
`define RTT_OFF_RESET_CAUSE_CONTROL 8'h00
`define RTT_OFF_IRQ_STAT 8'h04
`define RTT_OFF_IRQ_MASK 8'h08
`define RTT_OFF_CFG 8'h0C
`define RTT_OFF_STATUS 8'h10
`define RTT_RESET_CAUSE_CONTROL_POR 8'h1C
`define RTT_RESET_CAUSE_CONTROL_MASK 8'h9F
`define RTT_B_IRQ_PRIORITY_ENABLE 7
`define RTT_B_RI 4
`define RTT_B_TO 3
`define RTT_B_PD 2
`define RTT_B_POR 1
`define RTT_B_BOR 0
`define RTT_IRQ_DONE 0
`define RTT_IRQ_RESET 1
`define RTT_IRQ_WAKE 2
`define RTT_B_STK_OVF 1
`define RTT_B_STK_UNF 2
`define RTT_CFG_OSC_RST 3'h2
`define RTT_RESP_OK 2'h0
`define RTT_RESP_SLVERR 2'h2
`endif

// File: common/rtt_pkg.sv
// Types of the reset time-out and reset-cause tracker.
// Assumes an AXI4-Lite master with 8-bit byte addresses.
package rtt_pkg;
    typedef enum logic [2:0] {
        RTT_OSC_LP, RTT_OSC_XT, RTT_OSC_HS, RTT_OSC_HSPLL, RTT_OSC_EC, RTT_OSC_RC
    } rtt_osc_mode_t;
    typedef enum logic [2:0] {
        SQ_POWER, SQ_POWER_UP_DELAY_TIMER, SQ_OST, SQ_PLL, SQ_MASTER_CLEAR_PIN, SQ_RUN
    } rtt_state_t;
    typedef enum logic [3:0] {
        EV_NONE, EV_POR, EV_BOR, EV_MASTER_CLEAR_PIN, EV_MASTER_CLEAR_PIN_SLP, EV_WDT, EV_STK_FULL,
        EV_STK_UNF, EV_RESET_INSTR, EV_WAKE_WDT, EV_WAKE_IRQ, EV_OSC_SW
    } rtt_event_t;
    typedef struct packed {
        logic watchdogTimeout;
        logic resetInstr;
        logic stackFull;
        logic stackUnderflow;
        logic sleeping;
        logic irqWake;
        logic irqWakeHigh;
        logic highGie;
        logic lowGie;
        logic oscSwitch;
    } rtt_core_evt_t;
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } rtt_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } rtt_axi_rsp_t;
endpackage

// File: verif/rtt_far_side.sv
// Far-side model: supply detectors, master clear pin, crystal.
// Assumes the bench commands each level; crystal runs free at clk/8.
`timescale 1ns/1ps
`default_nettype none
module rtt_far_side (
    input wire logic clk,
    input wire logic rst,
    input wire logic porReq,
    input wire logic borReq,
    input wire logic mclrLow,
    output logic porPulsePin,
    output logic brownoutPin,
    output logic masterClearPin_n,
    output logic oscClkPin
);
    logic [1:0] div_reg;
    assign porPulsePin = porReq;
    assign brownoutPin = borReq;
    assign masterClearPin_n = !mclrLow;
    // Period of 8 clk keeps edges countable after the synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            oscClkPin <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) oscClkPin <= !oscClkPin;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb_rtt_reset_sequencer.sv
// Bench for the reset sequencer: register bus tasks, event scenarios.
// Assumes short time bases: 20 clk per ms, 8 crystal periods.
`timescale 1ns/1ps
`default_nettype none
module tb_rtt_reset_sequencer;
    import rtt_pkg::*;
    localparam int PW = 72 * 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic porReq = 1'b0;
    logic borReq = 1'b0;
    logic mclrLow = 1'b1;
    logic porPin, borPin, mclrPin_n, oscPin, hold, pcLoad, tosClear, prio, irq;
    rtt_core_evt_t evt = '0;
    logic [20:0] pc = 21'h000100;
    logic [20:0] pcValue;
    rtt_axi_req_t req = '0;
    rtt_axi_rsp_t rsp;
    int mismatches = 0;
    int numChecks = 0;
    int cyc = 0;
    int n;
    always #4 clk = !clk;
    rtt_far_side u_rtt_far_side (.clk(clk), .rst(rst), .porReq(porReq), .borReq(borReq),
        .mclrLow(mclrLow), .porPulsePin(porPin), .brownoutPin(borPin),
        .masterClearPin_n(mclrPin_n), .oscClkPin(oscPin));
    rtt_reset_sequencer #(.MS_CYCLES(20), .OST_PERIODS(8)) u_rtt_reset_sequencer (
        .clk(clk), .rst(rst), .porPulsePin(porPin), .brownoutPin(borPin),
        .masterClearPin_n(mclrPin_n), .oscClkPin(oscPin), .coreEvt(evt),
        .currentPc(pc), .axiReq(req), .axiRsp(rsp), .coreResetHold(hold),
        .pcLoad(pcLoad), .pcValue(pcValue), .tosClear(tosClear),
        .irqPriorityEnable(prio), .irq(irq));
    task automatic results();
        if (mismatches == 0 && numChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        numChecks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
        chk(rsp.rdata, d);
        chk({30'h0, rsp.rresp}, {30'h0, r});
    endtask
    task automatic wt();
        n = 0;
        while (hold === 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Pulse bits drop after one cycle, the sleep level stays
    task automatic ev(input logic [9:0] e);
        @(posedge clk);
        evt <= rtt_core_evt_t'(e);
        @(posedge clk);
        evt <= rtt_core_evt_t'(e & 10'h020);
        repeat (3) @(posedge clk);
        wt();
    endtask
    task automatic pin(input logic isPor);
        @(posedge clk);
        if (isPor) porReq <= 1'b1;
        else borReq <= 1'b1;
        repeat (4) @(posedge clk);
        porReq <= 1'b0;
        borReq <= 1'b0;
        repeat (3) @(posedge clk);
        wt();
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            mismatches++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h0000001C, 2'h0);
        rd(8'h20, 32'h00000000, 2'h2);
        repeat (1600) @(posedge clk);
        chk(hold, 1'b1);
        mclrLow <= 1'b0;
        wt();
        chk(n < 6, 1'b1);
        wr(8'h0C, 32'h00000003);
        pin(1'b1);
        chk(n >= PW + 90, 1'b1);
        chk(n < PW + 200, 1'b1);
        rd(8'h00, 32'h0000001C, 2'h0);
        wr(8'h0C, 32'h00000002);
        wr(8'h00, 32'h000000FF);
        rd(8'h00, 32'h0000009F, 2'h0);
        ev(10'h03C);
        chk(n > 40, 1'b1);
        chk(pcValue, 21'h000008);
        rd(8'h00, 32'h00000093, 2'h0);
        ev(10'h220);
        chk(pcValue, 21'h000102);
        ev(10'h100);
        chk(pcValue, 21'h000000);
        rd(8'h00, 32'h00000003, 2'h0);
        ev(10'h200);
        rd(8'h00, 32'h00000007, 2'h0);
        wr(8'h00, 32'h00000087);
        chk(prio, 1'b1);
        mclrLow <= 1'b1;
        repeat (6) @(posedge clk);
        mclrLow <= 1'b0;
        wt();
        chk(prio, 1'b0);
        rd(8'h00, 32'h00000007, 2'h0);
        wr(8'h00, 32'h00000004);
        ev(10'h080);
        rd(8'h00, 32'h00000007, 2'h0);
        rd(8'h10, 32'h00000002, 2'h0);
        wr(8'h08, 32'h00000002);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rd(8'h04, 32'h00000007, 2'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        wr(8'h0C, 32'h0000000D);
        pin(1'b0);
        chk(n < 6, 1'b1);
        rd(8'h00, 32'h0000001E, 2'h0);
        results();
    end
endmodule
`default_nettype wire

// File: verilog/rtt_reset_sequencer.sv
// Reset time-out sequencer and reset-cause recorder, AXI4-Lite slave.
// Assumes supply detectors, master clear and oscillator arrive asynchronously.
// Functional notes
// [R1] Power-up waits power-on pulse, then power-up delay, then oscillator count.
// [R2] External RC with delay disabled releases power-up reset with no time-out.
// [R3] Time-outs ignore master clear; release high then starts execution at once.
// [R4] Crystal with PLL adds 2 ms after 1024 periods; 72 ms first on power.
// [R5] Crystal without PLL: 1024 periods on wake; 72 ms first on power.
// [R6] External clock and RC: only 72 ms on power, nothing on wake.
// [R7] Power-up delay runs when its config bit is 0, skipped when 1.
// [R8] Cause register: priority enable bit 7, bits 6:5 zero, flags RI TO PD reset 1, POR BOR reset 0.
// [R9] Power-on: PC 0, set RI TO PD, clear POR BOR; brown-out keeps POR.
// [R10] Master clear while running: PC 0, clear priority enable, flags kept.
// [R11] Reset instruction: PC 0, clear RI, other flags kept.
// [R12] Stack-full reset: PC 0, set POR and BOR, record overflow.
// [R13] Stack-underflow reset: PC 0, set POR and BOR, record underflow.
// [R14] Master clear in sleep sets TO clears PD; watchdog reset opposite.
// [R15] Watchdog or interrupt wake: no reset, PC+2, clear TO and PD.
// [R16] Interrupt wake with global enable loads high or low vector.
// [R17] Resets clear stack top and PC; wakes keep them, PC advances two.
// [R18] Core held in reset while any time-out stage counts.
// [R19] Oscillator count only in crystal modes, after power-on, wake or oscillator switch.
`timescale 1ns/1ps
`default_nettype none
`include "rtt_consts.svh"
module rtt_reset_sequencer import rtt_pkg::*; #(
    parameter int unsigned MS_CYCLES = `RTT_MS_CYCLES,
    parameter int unsigned POWER_UP_DELAY_TIMER_MS = `RTT_POWER_UP_DELAY_TIMER_MS,
    parameter int unsigned PLL_MS = `RTT_PLL_MS,
    parameter int unsigned OST_PERIODS = `RTT_OST_PERIODS,
    parameter logic [2:0] OSC_MODE_RST = `RTT_CFG_OSC_RST,
    parameter logic POWER_UP_DELAY_TIMER_DIS_RST = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic porPulsePin,
    input wire logic brownoutPin,
    input wire logic masterClearPin_n,
    input wire logic oscClkPin,
    input wire rtt_core_evt_t coreEvt,
    input wire logic [20:0] currentPc,
    input wire rtt_axi_req_t axiReq,
    output rtt_axi_rsp_t axiRsp,
    output logic coreResetHold,
    output logic pcLoad,
    output logic [20:0] pcValue,
    output logic tosClear,
    output logic irqPriorityEnable,
    output logic irq
);
    localparam logic [10:0] POWER_UP_DELAY_TIMER_LAST = 11'(POWER_UP_DELAY_TIMER_MS - 1);
    localparam logic [10:0] PLL_LAST = 11'(PLL_MS - 1);
    localparam logic [10:0] OST_LAST = 11'(OST_PERIODS - 1);

    function automatic logic isAddr(logic [7:0] a, logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    function automatic logic regHit(logic [7:0] a);
        return isAddr(a, `RTT_OFF_RESET_CAUSE_CONTROL) || isAddr(a, `RTT_OFF_IRQ_STAT) ||
            isAddr(a, `RTT_OFF_IRQ_MASK) || isAddr(a, `RTT_OFF_CFG) ||
            isAddr(a, `RTT_OFF_STATUS);
    endfunction

    function automatic logic [7:0] rconAfter(rtt_event_t k, logic [7:0] c);
        logic [7:0] r;
        r = c;
        if (k != EV_NONE && k != EV_WAKE_WDT && k != EV_WAKE_IRQ && k != EV_OSC_SW) begin
            r[`RTT_B_IRQ_PRIORITY_ENABLE] = 1'b0;
        end
        case (k)
            EV_POR: begin
                r = `RTT_RESET_CAUSE_CONTROL_POR;
            end
            EV_BOR: begin // R9
                r[`RTT_B_RI] = 1'b1;
                r[`RTT_B_TO] = 1'b1;
                r[`RTT_B_PD] = 1'b1;
                r[`RTT_B_BOR] = 1'b0;
            end
            EV_MASTER_CLEAR_PIN_SLP: begin // R14
                r[`RTT_B_TO] = 1'b1;
                r[`RTT_B_PD] = 1'b0;
            end
            EV_WDT: begin
                r[`RTT_B_TO] = 1'b0;
                r[`RTT_B_PD] = 1'b1;
            end
            EV_STK_FULL, EV_STK_UNF: begin
                r[`RTT_B_POR] = 1'b1;
                r[`RTT_B_BOR] = 1'b1;
            end
            EV_RESET_INSTR: begin // R11
                r[`RTT_B_RI] = 1'b0;
            end
            EV_WAKE_WDT, EV_WAKE_IRQ: begin // R15
                r[`RTT_B_TO] = 1'b0;
                r[`RTT_B_PD] = 1'b0;
            end
            default: begin
                r = r;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pins, oscillator edges, time base
    logic [3:0] pinSync;
    logic oscPrev_reg;
    logic msTick;
    rtt_state_t state_reg, stateNext;
    logic [10:0] cnt_reg;
    logic [7:0] reset_cause_control_reg;
    logic [2:0] irqStat_reg, irqMask_reg;
    logic [3:0] cfg_reg;
    logic stkOvf_reg, stack_underflow_flag_reg;

    // Oscillator must stay below a quarter of clk to be counted reliably
    rtt_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({oscClkPin, masterClearPin_n, brownoutPin, porPulsePin}),
        .dout(pinSync)
    );

    wire logic porAct = pinSync[0];
    wire logic borAct = pinSync[1];
    wire logic mclrLow = ~pinSync[2];
    wire logic oscEdge = pinSync[3] & ~oscPrev_reg;
    wire logic powerAct = porAct | borAct;
    wire rtt_osc_mode_t oscMode = rtt_osc_mode_t'(cfg_reg[2:0]);
    wire logic pwrtDis = cfg_reg[3];
    wire logic crystal = (oscMode == RTT_OSC_LP) || (oscMode == RTT_OSC_XT) ||
        (oscMode == RTT_OSC_HS) || (oscMode == RTT_OSC_HSPLL);
    wire logic pllOn = (oscMode == RTT_OSC_HSPLL);
    wire logic inRun = (state_reg == SQ_RUN);
    wire logic tickClr = (stateNext != state_reg);

    rtt_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .clk(clk),
        .rst(rst),
        .clr(tickClr),
        .tick(msTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event selection, highest cause first
    wire rtt_event_t evKind =
        (powerAct && state_reg != SQ_POWER) ? (porAct ? EV_POR : EV_BOR) :
        !inRun ? EV_NONE :
        mclrLow ? (coreEvt.sleeping ? EV_MASTER_CLEAR_PIN_SLP : EV_MASTER_CLEAR_PIN) :
        coreEvt.watchdogTimeout ? (coreEvt.sleeping ? EV_WAKE_WDT : EV_WDT) :
        (coreEvt.sleeping && coreEvt.irqWake) ? EV_WAKE_IRQ :
        coreEvt.stackFull ? EV_STK_FULL :
        coreEvt.stackUnderflow ? EV_STK_UNF :
        coreEvt.resetInstr ? EV_RESET_INSTR :
        coreEvt.oscSwitch ? EV_OSC_SW : EV_NONE;
    wire logic isWake = (evKind == EV_WAKE_WDT) || (evKind == EV_WAKE_IRQ);
    wire logic isReset = (evKind != EV_NONE) && !isWake && (evKind != EV_OSC_SW);
    wire logic wakeHigh = (evKind == EV_WAKE_IRQ) && coreEvt.highGie && coreEvt.irqWakeHigh;
    wire logic wakeLow = (evKind == EV_WAKE_IRQ) && coreEvt.lowGie && !coreEvt.irqWakeHigh;
    wire logic [20:0] pcSel = isReset ? `RTT_PC_RESET : // R17
        wakeHigh ? `RTT_VEC_HIGH : // R16
        wakeLow ? `RTT_VEC_LOW :
        currentPc + `RTT_PC_STEP; // R15

    ////////////////////////////////////////////////////////////////////////
    // Time-out chain
    wire rtt_state_t finishSt = mclrLow ? SQ_MASTER_CLEAR_PIN : SQ_RUN; // R3
    wire rtt_state_t afterOst = pllOn ? SQ_PLL : finishSt; // R4
    wire rtt_state_t afterPwrt = crystal ? SQ_OST : finishSt; // R19 R6
    wire logic stageTick = (state_reg == SQ_OST) ? oscEdge :
        ((state_reg == SQ_POWER_UP_DELAY_TIMER) || (state_reg == SQ_PLL)) ? msTick : 1'b0;

    always_comb begin
        stateNext = state_reg;
        case (state_reg)
            SQ_POWER: begin
                if (!powerAct) begin
                    stateNext = pwrtDis ? afterPwrt : SQ_POWER_UP_DELAY_TIMER; // R7 R2
                end
            end
            SQ_POWER_UP_DELAY_TIMER: begin
                if (msTick && cnt_reg == POWER_UP_DELAY_TIMER_LAST) begin
                    stateNext = afterPwrt; // R1
                end
            end
            SQ_OST: begin
                if (oscEdge && cnt_reg == OST_LAST) begin
                    stateNext = afterOst; // R5
                end
            end
            SQ_PLL: begin
                if (msTick && cnt_reg == PLL_LAST) begin
                    stateNext = finishSt; // R4
                end
            end
            SQ_MASTER_CLEAR_PIN: begin
                if (!mclrLow) begin
                    stateNext = SQ_RUN; // R3
                end
            end
            SQ_RUN: begin
                if (isReset) begin
                    stateNext = SQ_MASTER_CLEAR_PIN;
                end else if ((isWake || evKind == EV_OSC_SW) && crystal) begin
                    stateNext = SQ_OST; // R19
                end
            end
            default: begin
                stateNext = SQ_POWER;
            end
        endcase
        // Supply dip restarts the chain from scratch
        if (powerAct) begin
            stateNext = SQ_POWER;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SQ_POWER;
            cnt_reg <= '0;
            oscPrev_reg <= 1'b0;
            coreResetHold <= 1'b1;
        end else begin
            state_reg <= stateNext;
            cnt_reg <= tickClr ? '0 : cnt_reg + 11'(stageTick);
            oscPrev_reg <= pinSync[3];
            coreResetHold <= (stateNext != SQ_RUN); // R18
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcLoad <= 1'b1;
            pcValue <= `RTT_PC_RESET;
            tosClear <= 1'b1;
        end else begin
            pcLoad <= isReset || isWake;
            pcValue <= (isReset || isWake) ? pcSel : pcValue;
            tosClear <= isReset; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg;
    logic [7:0] awAddr_reg, wByte_reg;
    logic wLane0_reg;
    logic [1:0] bResp_reg, rResp_reg;
    logic [31:0] rData_reg;

    wire logic awFire = axiReq.awvalid && awReady_reg;
    wire logic wFire = axiReq.wvalid && wReady_reg;
    wire logic arFire = axiReq.arvalid && arReady_reg;
    wire logic doWrite = !awReady_reg && !wReady_reg && !bValid_reg;
    wire logic wrEn = doWrite && wLane0_reg;
    wire logic wrRcon = wrEn && isAddr(awAddr_reg, `RTT_OFF_RESET_CAUSE_CONTROL);
    wire logic wrMask = wrEn && isAddr(awAddr_reg, `RTT_OFF_IRQ_MASK);
    wire logic wrCfg = wrEn && isAddr(awAddr_reg, `RTT_OFF_CFG);
    wire logic wrStat = wrEn && isAddr(awAddr_reg, `RTT_OFF_STATUS);
    wire logic rdIrq = arFire && isAddr(axiReq.araddr, `RTT_OFF_IRQ_STAT);
    wire logic [7:0] rconBase = wrRcon ? (wByte_reg & `RTT_RESET_CAUSE_CONTROL_MASK) : reset_cause_control_reg; // R8
    wire logic [7:0] rconNext = rconAfter(evKind, rconBase); // R9
    // Named runRelease: the plain word is a reserved keyword
    wire logic runRelease = !inRun && (stateNext == SQ_RUN);
    wire logic [2:0] irqEv = {isWake, isReset, runRelease};
    wire logic [2:0] irqStatNext = (rdIrq ? 3'h0 : irqStat_reg) | irqEv;
    wire logic [2:0] maskNext = wrMask ? wByte_reg[2:0] : irqMask_reg;
    wire logic [7:0] ar = axiReq.araddr;
    wire logic [31:0] rdMux =
        isAddr(ar, `RTT_OFF_RESET_CAUSE_CONTROL) ? {24'h000000, reset_cause_control_reg} :
        isAddr(ar, `RTT_OFF_IRQ_STAT) ? {29'h00000000, irqStat_reg} :
        isAddr(ar, `RTT_OFF_IRQ_MASK) ? {29'h00000000, irqMask_reg} :
        isAddr(ar, `RTT_OFF_CFG) ? {28'h0000000, cfg_reg} :
        isAddr(ar, `RTT_OFF_STATUS) ?
            {3'h0, pcValue, 5'h00, stack_underflow_flag_reg, stkOvf_reg, coreResetHold} :
        32'h00000000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awReady_reg <= 1'b1;
            wReady_reg <= 1'b1;
            bValid_reg <= 1'b0;
            bResp_reg <= `RTT_RESP_OK;
            awAddr_reg <= 8'h00;
            wByte_reg <= 8'h00;
            wLane0_reg <= 1'b0;
        end else begin
            awReady_reg <= awFire ? 1'b0 : ((bValid_reg && axiReq.bready) | awReady_reg);
            wReady_reg <= wFire ? 1'b0 : ((bValid_reg && axiReq.bready) | wReady_reg);
            bValid_reg <= doWrite | (bValid_reg && !axiReq.bready);
            bResp_reg <= doWrite ? (regHit(awAddr_reg) ? `RTT_RESP_OK : `RTT_RESP_SLVERR) :
                bResp_reg;
            awAddr_reg <= awFire ? axiReq.awaddr : awAddr_reg;
            wByte_reg <= wFire ? axiReq.wdata[7:0] : wByte_reg;
            wLane0_reg <= wFire ? axiReq.wstrb[0] : wLane0_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arReady_reg <= 1'b1;
            rValid_reg <= 1'b0;
            rData_reg <= 32'h00000000;
            rResp_reg <= `RTT_RESP_OK;
        end else begin
            arReady_reg <= arFire ? 1'b0 : ((rValid_reg && axiReq.rready) | arReady_reg);
            rValid_reg <= arFire | (rValid_reg && !axiReq.rready);
            rData_reg <= arFire ? rdMux : rData_reg;
            rResp_reg <= arFire ? (regHit(ar) ? `RTT_RESP_OK : `RTT_RESP_SLVERR) : rResp_reg;
        end
    end

    assign axiRsp = '{awready: awReady_reg, wready: wReady_reg, bresp: bResp_reg,
        bvalid: bValid_reg, arready: arReady_reg, rdata: rData_reg, rresp: rResp_reg,
        rvalid: rValid_reg};

    ////////////////////////////////////////////////////////////////////////
    // Cause flags, stack record, interrupt
    // Hardware causes override a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_cause_control_reg <= `RTT_RESET_CAUSE_CONTROL_POR;
            irqStat_reg <= 3'h0;
            irqMask_reg <= 3'h0;
            cfg_reg <= {POWER_UP_DELAY_TIMER_DIS_RST, OSC_MODE_RST};
            stkOvf_reg <= 1'b0;
            stack_underflow_flag_reg <= 1'b0;
            irq <= 1'b0;
        end else begin
            reset_cause_control_reg <= rconNext; // R10
            irqStat_reg <= irqStatNext;
            irqMask_reg <= maskNext;
            cfg_reg <= wrCfg ? wByte_reg[3:0] : cfg_reg;
            stkOvf_reg <= (evKind == EV_STK_FULL) |
                (stkOvf_reg & ~(wrStat & wByte_reg[`RTT_B_STK_OVF])); // R12
            stack_underflow_flag_reg <= (evKind == EV_STK_UNF) |
                (stack_underflow_flag_reg & ~(wrStat & wByte_reg[`RTT_B_STK_UNF])); // R13
            irq <= |(irqStatNext & maskNext);
        end
    end

    assign irqPriorityEnable = reset_cause_control_reg[`RTT_B_IRQ_PRIORITY_ENABLE];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_hold_while_count: assert property (!inRun |-> coreResetHold) // R18
        else $error("core released while time-out chain busy");
    a_power_up_delay_timer_config: assert property ((state_reg == SQ_POWER_UP_DELAY_TIMER) |-> !pwrtDis) // R7
        else $error("power-up delay ran while disabled");
    a_ost_mode: assert property ((state_reg == SQ_OST) |-> crystal) // R19
        else $error("oscillator count in non-crystal mode");
    a_pll_after_ost: assert property ($rose(state_reg == SQ_PLL) |->
        ($past(state_reg) == SQ_OST) && pllOn) // R4
        else $error("PLL delay not preceded by oscillator count");
    a_power_up_delay_timer_length: assert property ((state_reg == SQ_POWER_UP_DELAY_TIMER) && !powerAct &&
        (stateNext != SQ_POWER_UP_DELAY_TIMER) |-> msTick && (cnt_reg == POWER_UP_DELAY_TIMER_LAST)) // R5
        else $error("power-up delay ended early");
    a_chain_order: assert property ($rose(state_reg == SQ_OST) |->
        $past(state_reg) inside {SQ_POWER, SQ_POWER_UP_DELAY_TIMER, SQ_RUN}) // R1
        else $error("oscillator count entered out of order");
    a_rc_no_wait: assert property ((state_reg == SQ_POWER) && !powerAct && pwrtDis &&
        !crystal && !mclrLow |=> inRun) // R2
        else $error("time-out applied with delay disabled");
    a_master_clear_pin_release: assert property ((state_reg == SQ_MASTER_CLEAR_PIN) && !mclrLow && !powerAct
        |=> inRun ##1 !coreResetHold) // R3
        else $error("execution not started on master clear release");
    a_por_flags: assert property ((evKind == EV_POR) |=> reset_cause_control_reg == `RTT_RESET_CAUSE_CONTROL_POR) // R9
        else $error("power-on flags wrong");
    a_instr_flags: assert property ((evKind == EV_RESET_INSTR) && !wrRcon |=>
        !reset_cause_control_reg[`RTT_B_RI] && reset_cause_control_reg[3:0] == $past(reset_cause_control_reg[3:0])) // R11
        else $error("reset instruction flags wrong");
    a_wdt_flags: assert property ((evKind == EV_WDT) |=>
        !reset_cause_control_reg[`RTT_B_TO] && reset_cause_control_reg[`RTT_B_PD] && pcLoad && pcValue == 21'h0) // R14
        else $error("watchdog reset flags wrong");
    a_wake_pc: assert property (isWake && !wakeHigh && !wakeLow |=>
        pcLoad && pcValue == $past(currentPc) + 21'h000002 && !tosClear) // R15
        else $error("wake did not continue at PC plus two");
    a_stack_flags: assert property ((evKind == EV_STK_FULL) |=>
        stkOvf_reg && reset_cause_control_reg[1:0] == 2'h3) // R12
        else $error("stack-full reset flags wrong");
endmodule
`default_nettype wire

// File: verilog/rtt_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module rtt_sync #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            dout <= '0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// File: verilog/rtt_tick.sv
// Divider giving a one-cycle enable every CYCLES clocks.
// Assumes clr restarts the period so a stage never gets a short first tick.
`timescale 1ns/1ps
`default_nettype none
module rtt_tick #(
    parameter int unsigned CYCLES = 125000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    output logic tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (clr) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
            tick <= (cnt_reg == LAST);
        end
    end
endmodule
`default_nettype wire
